/* File: hdl/udt_core.sv */
// Counter core: prescaler, 16-bit count, reload and clock-out toggle.
// Assumes synchronised pins and a decoded configuration.
`timescale 1ns/1ps
`include "udt_params.svh"
module udt_core (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    // Configuration
    input  udt_pkg::udt_cfg_t     cfg,
    input  wire logic [15:0]      reload,
    input  wire logic             dir_up,
    input  wire logic             pin_fall,
    input  wire logic             cnt_wr,
    input  wire logic [15:0]      cnt_wdata,
    // Results
    output logic [15:0]           count,
    output logic                  clk_out,
    output udt_pkg::udt_evt_t     evt
);
    logic [3:0]  pre;
    logic [3:0]  next_pre;
    logic [15:0] next_count;
    logic        next_clk_out;
    logic        tick;
    logic        wrap;

    // Tick source: oscillator/2 in clock-out, /12 timer, or pin edge
    always_comb begin
        tick = 1'b0;
        next_pre = pre;
        if (cfg.run) begin
            if (cfg.clock_out_enable && !cfg.counter_select) begin
                tick = (pre >= 4'(`UDT_CLKOUT_DIV - 1));
                next_pre = tick ? 4'h0 : pre + 4'h1;
            end else if (cfg.counter_select) begin
                tick = pin_fall;
            end else begin
                tick = (pre >= 4'(`UDT_TIMER_DIV - 1));
                next_pre = tick ? 4'h0 : pre + 4'h1;
            end
        end
    end

    // Count update; reload on wrap keeps period 65536-reload ticks
    always_comb begin
        next_count   = count;
        next_clk_out = clk_out;
        wrap         = 1'b0;
        evt          = '0;
        if (cnt_wr) begin
            next_count = cnt_wdata;
        end else if (tick) begin
            if (cfg.updown_enable && !dir_up && !cfg.clock_out_enable
                && !cfg.capture_reload_select) begin
                if (count == reload) begin
                    next_count = `UDT_ALL_ONES;
                    wrap = 1'b1;
                end else begin
                    next_count = count - 16'h0001;
                end
            end else if (count == `UDT_ALL_ONES) begin
                wrap = 1'b1;
                next_count = reload;
            end else begin
                next_count = count + 16'h0001;
            end
        end
        if (wrap && cfg.clock_out_enable)
            next_clk_out = ~clk_out;
        evt.overflow   = wrap && !cfg.serial_clock && !cfg.clock_out_enable;
        evt.ext_toggle = wrap && cfg.updown_enable && !cfg.clock_out_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre     <= 4'h0;
            count   <= `UDT_COUNT_RESET;
            clk_out <= 1'b0;
        end else if (ce) begin
            pre     <= next_pre;
            count   <= next_count;
            clk_out <= next_clk_out;
        end
    end

    reload_on_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !cnt_wr && wrap && next_count != `UDT_ALL_ONES)
        |=> count == $past(reload)) else $error("count not reloaded");
    down_to_ones_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && tick && !cnt_wr && cfg.updown_enable && !dir_up && !cfg.clock_out_enable
         && !cfg.capture_reload_select && count == reload)
        |=> count == `UDT_ALL_ONES) else $error("no underflow reload");
    hold_stopped_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cfg.run && !cnt_wr) |=> $stable(count)) else $error("count moved");
    no_clkout_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg.clock_out_enable |-> !evt.overflow) else $error("clock-out irq");
endmodule

/* File: hdl/udt_params.svh */
// Constants for the up/down reload clock-out timer: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the modules; the package does not include it.
//
// What this block does
// - Sixteen-bit count from cascaded high/low bytes
// - Select bit picks oscillator/12 or count pin
// - Count advances only while run bit set
// - Serial clock and capture bits choose mode
// - Updown enable clear gives plain up reload
// - Direction high counts up, all-ones overflow interrupts
// - Upward overflow copies reload pair into count
// - Direction low: count equals reload underflows to ones
// - External flag toggles per wrap, no interrupt
// - Clock-out advances at oscillator/2, 50% duty
// - Clock-out overflow reloads, raises no interrupt
// - Output frequency osc over 4*(65536-reload)
// - Generated clock drives the count pin
// - Baud and clock-out share one reload pair
// - Overflow flag only without serial clocks; software clears
// - Counter mode counts count-pin falling edges
// - Output enable makes count pin an output
`ifndef UDT_PARAMS_SVH
`define UDT_PARAMS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define UDT_OFF_CTRL    8'h00
`define UDT_OFF_MODE    8'h04
`define UDT_OFF_COUNT   8'h08
`define UDT_OFF_RELOAD  8'h0C
`define UDT_OFF_STATUS  8'h10
`define UDT_OFF_MASK    8'h14

// ------------------------------------------------------------
// Control, mode and status field positions
// ------------------------------------------------------------
`define UDT_CTL_CAP_RELOAD  0
`define UDT_CTL_CNT_SEL     1
`define UDT_CTL_RUN         2
`define UDT_CTL_EXT_EN      3
`define UDT_CTL_TX_CLK      4
`define UDT_CTL_RX_CLK      5
`define UDT_CTL_EXT_FLAG    6
`define UDT_CTL_OVF_FLAG    7
`define UDT_MOD_UPDOWN      0
`define UDT_MOD_CLK_OUT     1
`define UDT_ST_OVF          0
`define UDT_ST_EXT          1

// ------------------------------------------------------------
// Reset values, count limit, timing and response codes
// ------------------------------------------------------------
`define UDT_CTRL_RESET      8'h00
`define UDT_MODE_RESET      2'b00
`define UDT_COUNT_RESET     16'h0000
`define UDT_ALL_ONES        16'hFFFF
`define UDT_TIMER_DIV       12
`define UDT_CLKOUT_DIV      2
`define UDT_RESP_OKAY       2'b00
`define UDT_RESP_SLVERR     2'b10

`endif

/* File: hdl/udt_pkg.sv */
// Types shared by the timer files.
// Assumes nothing beyond the params header.
package udt_pkg;

    // Count source and direction setup decoded from control registers
    typedef struct packed {
        logic run;
        logic counter_select;
        logic updown_enable;
        logic clock_out_enable;
        logic serial_clock;
        logic capture_reload_select;
    } udt_cfg_t;

    // Events from the counter core, one-cycle pulses
    typedef struct packed {
        logic overflow;
        logic ext_toggle;
    } udt_evt_t;

    typedef enum logic [1:0] {
        udt_idle,
        udt_resp
    } udt_bus_state_t;

endpackage

/* File: hdl/udt_sync.sv */
// Two-flop synchroniser with falling-edge detect for one pin.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/1ps
`include "udt_params.svh"
module udt_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // Pin and results
    input  wire logic pin,
    output logic      level,
    output logic      fall
);
    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    // First flop is read only by the second
    always_comb begin
        next_meta = pin;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else if (ce) begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    assign level = sync;
    assign fall  = prev & ~sync;
endmodule

/* File: hdl/udt_timer.sv */
// Top: AXI4-Lite register slave around the up/down clock-out timer.
// Assumes one 40 MHz clock; pins are asynchronous and synchronised here.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "udt_params.svh"
module udt_timer (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        count_pin_i,
    output logic             count_pin_o,
    output logic             count_pin_oe,
    input  wire logic        direction_pin,
    // Interrupt
    output logic             irq
);
    logic [7:0]  timer_control_reg;
    logic [1:0]  timer_mode_reg;
    logic [15:0] reload_pair;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [7:0]  next_ctrl;
    logic [1:0]  next_mode;
    logic [15:0] next_reload;
    logic [1:0]  next_status;
    logic [1:0]  next_mask;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_aw_held;
    logic        next_w_held;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        do_write;
    logic        cnt_wr;
    logic        dir_level;
    logic        pin_fall;
    logic [15:0] count;
    logic        clk_out;
    udt_pkg::udt_cfg_t cfg;
    udt_pkg::udt_evt_t evt;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    udt_sync u_dir_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin     (direction_pin),
        .level   (dir_level),
        .fall    ()
    );

    udt_sync u_cnt_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .pin     (count_pin_i),
        .level   (),
        .fall    (pin_fall)
    );

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    // Serial clock bits force reload; capture is not modelled beyond mode select
    always_comb begin
        cfg.run                   = timer_control_reg[`UDT_CTL_RUN];
        cfg.counter_select        = timer_control_reg[`UDT_CTL_CNT_SEL];
        cfg.updown_enable         = timer_mode_reg[`UDT_MOD_UPDOWN];
        cfg.clock_out_enable      = timer_mode_reg[`UDT_MOD_CLK_OUT];
        cfg.serial_clock          = timer_control_reg[`UDT_CTL_TX_CLK]
                                  | timer_control_reg[`UDT_CTL_RX_CLK];
        cfg.capture_reload_select = timer_control_reg[`UDT_CTL_CAP_RELOAD]
                                  & ~cfg.serial_clock;
    end

    udt_core u_core (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .cfg       (cfg),
        .reload    (reload_pair),
        .dir_up    (dir_level),
        .pin_fall  (pin_fall),
        .cnt_wr    (cnt_wr),
        .cnt_wdata (w_data[15:0]),
        .count     (count),
        .clk_out   (clk_out),
        .evt       (evt)
    );

    // Pin drive: clock-out only while enabled
    assign count_pin_oe = timer_mode_reg[`UDT_MOD_CLK_OUT];
    assign count_pin_o  = clk_out;

    // ------------------------------------------------------------
    // AXI4-Lite write and read channels
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held && ce;
    assign s_axi_wready  = !w_held && ce;
    assign s_axi_arready = !s_axi_rvalid && ce;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign cnt_wr        = do_write && (aw_addr == `UDT_OFF_COUNT) && ce;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (aw_addr <= `UDT_OFF_MASK && aw_addr[1:0] == 2'b00)
                         ? `UDT_RESP_OKAY : `UDT_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // Read mux; unmapped addresses answer SLVERR with zero data
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_arvalid && !s_axi_rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = `UDT_RESP_OKAY;
            unique case (s_axi_araddr)
                `UDT_OFF_CTRL:   next_rdata = {24'h00_0000, timer_control_reg};
                `UDT_OFF_MODE:   next_rdata = {30'h0000_0000, timer_mode_reg};
                `UDT_OFF_COUNT:  next_rdata = {16'h0000, count};
                `UDT_OFF_RELOAD: next_rdata = {16'h0000, reload_pair};
                `UDT_OFF_STATUS: next_rdata = {30'h0000_0000, irq_status};
                `UDT_OFF_MASK:   next_rdata = {30'h0000_0000, irq_mask};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `UDT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle
    always_comb begin
        next_ctrl   = timer_control_reg;
        next_mode   = timer_mode_reg;
        next_reload = reload_pair;
        next_status = irq_status;
        next_mask   = irq_mask;
        if (do_write && w_strb[0]) begin
            unique case (aw_addr)
                `UDT_OFF_CTRL:   next_ctrl = w_data[7:0];
                `UDT_OFF_MODE:   next_mode = w_data[1:0];
                `UDT_OFF_RELOAD: next_reload[7:0] = w_data[7:0];
                `UDT_OFF_STATUS: next_status = irq_status & ~w_data[1:0];
                `UDT_OFF_MASK:   next_mask = w_data[1:0];
                default: ;
            endcase
        end
        if (do_write && w_strb[1] && aw_addr == `UDT_OFF_RELOAD)
            next_reload[15:8] = w_data[15:8];
        if (evt.overflow) begin
            next_ctrl[`UDT_CTL_OVF_FLAG] = 1'b1;
            next_status[`UDT_ST_OVF]     = 1'b1;
        end
        if (evt.ext_toggle)
            next_ctrl[`UDT_CTL_EXT_FLAG] = ~timer_control_reg[`UDT_CTL_EXT_FLAG];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control_reg <= `UDT_CTRL_RESET;
            timer_mode_reg    <= `UDT_MODE_RESET;
            reload_pair       <= `UDT_COUNT_RESET;
            irq_status        <= 2'b00;
            irq_mask          <= 2'b00;
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= 8'h00;
            w_data            <= 32'h0000_0000;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `UDT_RESP_OKAY;
            s_axi_rvalid      <= 1'b0;
            s_axi_rdata       <= 32'h0000_0000;
            s_axi_rresp       <= `UDT_RESP_OKAY;
        end else if (ce) begin
            timer_control_reg <= next_ctrl;
            timer_mode_reg    <= next_mode;
            reload_pair       <= next_reload;
            irq_status        <= next_status;
            irq_mask          <= next_mask;
            aw_held           <= next_aw_held;
            w_held            <= next_w_held;
            aw_addr           <= next_aw_addr;
            w_data            <= next_w_data;
            w_strb            <= next_w_strb;
            s_axi_bvalid      <= next_bvalid;
            s_axi_bresp       <= next_bresp;
            s_axi_rvalid      <= next_rvalid;
            s_axi_rdata       <= next_rdata;
            s_axi_rresp       <= next_rresp;
        end
    end

    // Level interrupt from unmasked sticky status
    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Flags and pin
    ovf_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && evt.overflow) |=> timer_control_reg[`UDT_CTL_OVF_FLAG])
        else $error("overflow flag not set");

    no_flag_serial_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && cfg.serial_clock && !timer_control_reg[`UDT_CTL_OVF_FLAG] && !do_write)
        |=> !timer_control_reg[`UDT_CTL_OVF_FLAG])
        else $error("flag with serial clock");

    ext_toggles_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && evt.ext_toggle) |=> timer_control_reg[`UDT_CTL_EXT_FLAG]
        != $past(timer_control_reg[`UDT_CTL_EXT_FLAG])) else $error("no toggle");

    // Undriven pin holds its level
    pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !count_pin_oe |=> $stable(count_pin_o))
        else $error("pin moved undriven");

    // Hardware set beats a clear
    status_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && evt.overflow) |=> irq_status[`UDT_ST_OVF])
        else $error("status lost");

    // Count load lands next edge
    count_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_wr |=> count == $past(w_data[15:0]))
        else $error("count not loaded");

    // Answers stand until taken
    bvalid_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("bvalid dropped");

    rvalid_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer moved");

    // Held pair answered next edge
    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && do_write) |=> s_axi_bvalid)
        else $error("no write answer");
endmodule

/* File: sim/udt_pins.sv */
// Far-side pin model: count pin source with pull-up, direction level.
// Assumes the timer drives the count pin only while its enable is high.
`timescale 1ns/1ps
module udt_pins (
    // Timer side
    input  wire logic aclk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    // Pin levels seen by the timer
    output logic      pin_i,
    output logic      dir
);
    logic src = 1'b1;

    // Wire level from both drivers; pull-up while nobody drives
    assign pin_i = pin_oe ? pin_o : src;
    initial dir = 1'b1;

    // One falling edge, held low long enough to pass the synchroniser
    task automatic pulse();
        @(posedge aclk);
        src <= 1'b0;
        repeat (4) @(posedge aclk);
        src <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask

    // Direction change, then settle time for the two-flop lag
    task automatic set_dir(input logic up);
        @(posedge aclk);
        dir <= up;
        repeat (4) @(posedge aclk);
    endtask
endmodule

/* File: sim/udt_timer_test.sv */
// Self-checking bench: AXI4-Lite master tasks and one task per scenario.
// Assumes the pin model drives the count and direction pins.
`timescale 1ns/1ps
`include "udt_params.svh"
module udt_timer_test;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] rdata;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        pin_o, pin_oe, pin_i, dir, irq;
    int          n_errors = 0;
    int          num_checks = 0;

    // 40 MHz clock
    always #12.5 aclk = ~aclk;

    udt_timer u_udt_timer (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_pin_i(pin_i),
        .count_pin_o(pin_o), .count_pin_oe(pin_oe), .direction_pin(dir), .irq(irq));

    udt_pins u_udt_pins (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_i(pin_i), .dir(dir));

    // Verdict and end of run
    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // A wait that ran out of cycles ends the run as a mismatch
    task automatic hang();
        n_errors++;
        finish_test();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int i;
        logic ta, tw;
        i = 0;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (++i > 50) hang();
            if (awready === 1'b1) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) begin
            @(posedge aclk);
            if (++i > 100) hang();
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        i = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (++i > 50) hang();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            if (++i > 100) hang();
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, {16'h0000, e}, d);
    endtask

    // Judges the overflow event bit only
    task automatic st(input logic e, input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        rd(`UDT_OFF_STATUS, d, r);
        chk(nm, {31'd0, e}, {31'd0, d[0]});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rc(`UDT_OFF_CTRL, 16'h0000, "control");
        rc(`UDT_OFF_MODE, 16'h0000, "mode");
        rc(`UDT_OFF_COUNT, 16'h0000, "count");
        chk("pin enable", 0, pin_oe);
        chk("irq", 0, irq);
        rd(8'h18, d, r);
        chk("unmapped resp", {30'd0, `UDT_RESP_SLVERR}, {30'd0, r});
        chk("unmapped data", 0, d);
        wr(8'h18, 16'h0001);
        chk("unmapped write resp", {30'd0, `UDT_RESP_SLVERR}, {30'd0, bresp});
    endtask

    // Timer source ticks once per twelve clocks, then holds when stopped
    task automatic t_timer();
        logic [31:0] d;
        logic [1:0]  r;
        wr(`UDT_OFF_COUNT, 16'h0000);
        wr(`UDT_OFF_CTRL, 16'h0004);
        repeat (120) @(posedge aclk);
        ce <= 1'b0;
        repeat (120) @(posedge aclk);
        ce <= 1'b1;
        wr(`UDT_OFF_CTRL, 16'h0000);
        rd(`UDT_OFF_COUNT, d, r);
        chk("timer ticks", 1, {31'd0, d inside {32'd10, 32'd11}});
        repeat (60) @(posedge aclk);
        rc(`UDT_OFF_COUNT, d[15:0], "held count");
    endtask

    // Counter source, up then down across the wrap points
    task automatic t_updown();
        wr(`UDT_OFF_MODE, 16'h0001);
        wr(`UDT_OFF_RELOAD, 16'h1234);
        wr(`UDT_OFF_COUNT, 16'hFFFE);
        wr(`UDT_OFF_MASK, 16'h0001);
        wr(`UDT_OFF_CTRL, 16'h0006);
        u_udt_pins.pulse();
        u_udt_pins.pulse();
        rc(`UDT_OFF_COUNT, 16'h1234, "count after overflow");
        rc(`UDT_OFF_CTRL, 16'h00C6, "control flags");
        st(1'b1, "overflow event");
        chk("irq", 1, irq);
        wr(`UDT_OFF_MASK, 16'h0000);
        chk("irq masked", 0, irq);
        wr(`UDT_OFF_MASK, 16'h0001);
        wr(`UDT_OFF_STATUS, 16'h0001);
        chk("irq cleared", 0, irq);
        u_udt_pins.set_dir(1'b0);
        wr(`UDT_OFF_COUNT, 16'h1235);
        u_udt_pins.pulse();
        u_udt_pins.pulse();
        rc(`UDT_OFF_COUNT, 16'hFFFF, "count after underflow");
        rc(`UDT_OFF_CTRL, 16'h0086, "flags after underflow");
        st(1'b1, "underflow event");
    endtask

    // Serial clock select forces reload but keeps the flag quiet
    task automatic t_serial();
        wr(`UDT_OFF_STATUS, 16'h0001);
        u_udt_pins.set_dir(1'b1);
        wr(`UDT_OFF_COUNT, 16'hFFFF);
        wr(`UDT_OFF_CTRL, 16'h0017);
        u_udt_pins.pulse();
        rc(`UDT_OFF_COUNT, 16'h1234, "serial reload");
        st(1'b0, "serial overflow event");
        chk("serial irq", 0, irq);
    endtask

    // Measure the pin between its edges, sampled once per clock
    task automatic level_wait(input logic v, output int n);
        n = 0;
        while (pin_o !== v) begin
            @(posedge aclk);
            if (++n > 200) hang();
        end
    endtask

    task automatic t_clkout();
        int n, h, l;
        wr(`UDT_OFF_CTRL, 16'h0000);
        wr(`UDT_OFF_MODE, 16'h0002);
        wr(`UDT_OFF_RELOAD, 16'hFFFC);
        wr(`UDT_OFF_COUNT, 16'hFFFC);
        wr(`UDT_OFF_STATUS, 16'h0003);
        wr(`UDT_OFF_MASK, 16'h0003);
        wr(`UDT_OFF_CTRL, 16'h0024);
        chk("pin enable", 1, pin_oe);
        level_wait(1'b0, n);
        level_wait(1'b1, n);
        level_wait(1'b0, h);
        level_wait(1'b1, l);
        chk("clock high", 8, h);
        chk("clock low", 8, l);
        chk("pin level", {31'd0, pin_o}, {31'd0, pin_i});
        chk("clock-out irq", 0, irq);
        st(1'b0, "clock-out event");
    endtask

    // Main sequence: reset held six cycles, then each scenario in turn
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_timer();
        t_updown();
        t_serial();
        t_clkout();
        finish_test();
    end
endmodule
